// ---- design/nvac_ctrl.sv ----
// Access control for an on-chip byte-wide nonvolatile data memory.
// Assumes an APB master, a memory array inside, an RC oscillator tick.
//
// Overview of operation
// RQ1: Write strobe clears itself when programming time elapses.
// RQ2: Setting write strobe stalls the processor two cycles.
// RQ3: Writing one to read strobe reads byte at loaded address.
// RQ4: Read result lands in data register within that access.
// RQ5: Every read stalls the processor four cycles.
// RQ6: During programming reads are ignored, address writes refused.
// RQ7: Programming lasts 26368 calibrated RC oscillator ticks.
// RQ8: Software polls write strobe for zero before next byte.
// RQ9: Software checks write strobe is zero before any read.
// RQ10: Software waits for self_program_command completion first.
// RQ11: Software loads address and data, arms, then sets write strobe.
// RQ12: Software loads address, sets read strobe, then reads data.
// RQ13: Software keeps interrupts off during access routines; the bench's nv_write and nv_read set GIE and RIE.
// RQ14: Arm bit clears after four cycles; strobe needs it set.
// RQ15: Mode field selects action; frozen while write strobe set.
// RQ16: Ready interrupt asserts while write strobe clear, if enabled.
// RQ17: Twelve-bit address; upper high-byte bits read zero.
// RQ18: Data register held unchanged while programming.
`timescale 1ns/100ps
module nvac_ctrl
	import nvac_pkg::*;
#(
	parameter int P_PROG_OSC = NVAC_PROG_OSC,
	parameter int P_DEPTH    = 4096
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_osc_tick,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_cpu_stall,
	output logic             o_ready_irq,
	output logic             o_irq
);
	initial begin
		if (P_PROG_OSC < 1 || P_DEPTH < 1 || P_DEPTH > 4096)
			$error("nvac_ctrl: bad parameter");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [NVAC_ADDR_W-1:0] addr;
		logic [7:0]             data;
		logic                   wr;
		logic                   arm;
		logic [2:0]             arm_cnt;
		logic                   rie;
		logic                   gie;
		logic [1:0]             pm;
		logic [1:0]             pm_act;
		logic [14:0]            prog_cnt;
		logic [2:0]             stall;
		logic [NVAC_NSTAT-1:0]  stat;
		logic [NVAC_NSTAT-1:0]  mask;
		logic [31:0]            rdata;
		logic                   tick_s1;
		logic                   tick_s2;
		logic                   tick_s3;
	} nvac_state_s;

	nvac_state_s st_reg;
	nvac_state_s st_next;
	logic [7:0]  mem [P_DEPTH];
	logic        mem_we;
	logic [7:0]  mem_rd;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	wire acc    = i_psel && i_penable;
	wire wr_acc = acc && i_pwrite;
	wire busy   = st_reg.wr;
	wire tick   = st_reg.tick_s2 && !st_reg.tick_s3;
	wire ctl_wr = wr_acc && hit(i_paddr, NVAC_OFF_CTRL);

	assign mem_rd = mem[st_reg.addr[$clog2(P_DEPTH)-1:0]];

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [NVAC_NSTAT-1:0] ev;
		ev      = '0;
		st_next = st_reg;
		mem_we  = 1'b0;
		st_next.tick_s1 = i_osc_tick;
		st_next.tick_s2 = st_reg.tick_s1;
		st_next.tick_s3 = st_reg.tick_s2;
		if (st_reg.stall != 3'h0)
			st_next.stall = st_reg.stall - 3'h1;
		// Arm window times out
		if (st_reg.arm) begin
			if (st_reg.arm_cnt == 3'(NVAC_ARM_CYC - 1))
				st_next.arm = 1'b0; // RQ14
			else
				st_next.arm_cnt = st_reg.arm_cnt + 3'h1;
		end
		// Programming timed on oscillator ticks
		if (busy && tick) begin
			if (st_reg.prog_cnt == 15'(P_PROG_OSC - 1)) begin
				st_next.wr = 1'b0; // RQ1
				ev[NVAC_S_WDONE] = 1'b1;
				if (st_reg.pm_act != NVAC_PM_RSVD)
					mem_we = 1'b1; // RQ7
			end else begin
				st_next.prog_cnt = st_reg.prog_cnt + 15'h1; // RQ7
			end
		end
		if (wr_acc) begin
			if (hit(i_paddr, NVAC_OFF_ADDR_LO) && !busy)
				st_next.addr[7:0] = i_pwdata[7:0]; // RQ6
			if (hit(i_paddr, NVAC_OFF_ADDR_HI) && !busy)
				st_next.addr[11:8] = i_pwdata[3:0]; // RQ6 RQ17
			if (hit(i_paddr, NVAC_OFF_DATA) && !busy)
				st_next.data = i_pwdata[7:0]; // RQ18
			if (hit(i_paddr, NVAC_OFF_MASK))
				st_next.mask = i_pwdata[NVAC_NSTAT-1:0];
			if (hit(i_paddr, NVAC_OFF_STAT))
				st_next.stat = st_reg.stat & ~i_pwdata[NVAC_NSTAT-1:0];
		end
		if (ctl_wr) begin
			st_next.rie = i_pwdata[NVAC_B_RIE];
			st_next.gie = i_pwdata[NVAC_B_GIE];
			if (!busy)
				st_next.pm = i_pwdata[NVAC_B_PM_LO +: 2]; // RQ15
			if (i_pwdata[NVAC_B_ARM]) begin
				st_next.arm     = 1'b1; // RQ14
				st_next.arm_cnt = 3'h0;
			end
			// Strobe only starts programming inside the arm window
			if (i_pwdata[NVAC_B_WR] && !busy && st_reg.arm) begin
				st_next.wr       = 1'b1; // RQ14
				st_next.arm      = 1'b0;
				st_next.pm_act   = st_reg.pm;
				st_next.prog_cnt = '0;
				st_next.stall    = 3'(NVAC_WR_STALL); // RQ2
			end else if (i_pwdata[NVAC_B_RD] && !busy) begin
				st_next.data  = mem_rd; // RQ3 RQ4
				st_next.stall = 3'(NVAC_RD_STALL); // RQ5
				ev[NVAC_S_RDONE] = 1'b1;
			end
		end
		// Set wins over a simultaneous clear
		ev[NVAC_S_READY] = busy && !st_next.wr;
		st_next.stat = st_next.stat | ev;
		st_next.rdata = '0;
		if (i_psel && !i_penable && !i_pwrite) begin
			case (i_paddr)
				NVAC_OFF_ADDR_LO: st_next.rdata = {24'h0, st_reg.addr[7:0]};
				NVAC_OFF_ADDR_HI: st_next.rdata = {28'h0, st_reg.addr[11:8]};
				NVAC_OFF_DATA:    st_next.rdata = {24'h0, st_reg.data};
				NVAC_OFF_CTRL:    st_next.rdata = {25'h0, st_reg.gie,
					st_reg.pm, st_reg.rie, st_reg.arm, st_reg.wr, 1'b0};
				NVAC_OFF_STAT:    st_next.rdata = 32'(st_reg.stat);
				NVAC_OFF_MASK:    st_next.rdata = 32'(st_reg.mask);
				default:          st_next.rdata = 32'h0;
			endcase
		end else if (acc) begin
			st_next.rdata = st_reg.rdata;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg    <= '0;
			st_reg.pm <= NVAC_PM_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Memory array has no reset: contents are nonvolatile
	always_ff @(posedge i_ref_clk) begin
		if (mem_we)
			mem[st_reg.addr[$clog2(P_DEPTH)-1:0]] <=
				(st_reg.pm_act == 2'h1) ? 8'hff : st_reg.data;
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		o_prdata    = st_reg.rdata;
		o_pready    = 1'b1;
		o_pslverr   = acc && !(hit(i_paddr, NVAC_OFF_ADDR_LO) ||
			hit(i_paddr, NVAC_OFF_ADDR_HI) || hit(i_paddr, NVAC_OFF_DATA) ||
			hit(i_paddr, NVAC_OFF_CTRL) || hit(i_paddr, NVAC_OFF_STAT) ||
			hit(i_paddr, NVAC_OFF_MASK));
		o_cpu_stall = st_reg.stall != 3'h0;
		o_ready_irq = st_reg.rie && st_reg.gie && !st_reg.wr; // RQ16
		o_irq       = |(st_reg.stat & st_reg.mask);
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_arm_timeout: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ14
		$rose(st_reg.arm) && !ctl_wr |-> ##[1:4] !st_reg.arm)
		else $error("arm bit outlived its window");
	chk_wr_stall: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ2
		$rose(st_reg.wr) |-> o_cpu_stall ##1 o_cpu_stall ##1 !o_cpu_stall)
		else $error("write stall not two cycles");
	chk_rd_stall: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ5
		ctl_wr && i_pwdata[NVAC_B_RD] && !busy && !(i_pwdata[NVAC_B_WR] &&
		st_reg.arm) |=> o_cpu_stall [*4] ##1 !o_cpu_stall)
		else $error("read stall not four cycles");
	chk_rd_data: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ4
		ctl_wr && i_pwdata[NVAC_B_RD] && !busy && !(i_pwdata[NVAC_B_WR] &&
		st_reg.arm) |=> st_reg.data == $past(mem_rd))
		else $error("read data not loaded");
	chk_addr_frozen: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ6
		busy |=> st_reg.addr == $past(st_reg.addr))
		else $error("address changed during programming");
	chk_data_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ18
		busy |=> st_reg.data == $past(st_reg.data))
		else $error("data changed during programming");
	chk_pm_frozen: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ15
		busy |=> st_reg.pm == $past(st_reg.pm))
		else $error("mode changed during programming");
	chk_wr_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ1
		busy && tick && st_reg.prog_cnt == 15'(P_PROG_OSC - 1) |=> !st_reg.wr)
		else $error("write strobe not cleared");
	chk_prog_count: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ7
		busy && !tick |=> st_reg.prog_cnt == $past(st_reg.prog_cnt))
		else $error("programming counter moved without tick");
	chk_ready_irq: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ16
		$fell(st_reg.wr) && st_reg.rie && st_reg.gie |-> o_ready_irq)
		else $error("ready interrupt missing");
	chk_arm_needed: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ14
		!busy && !st_reg.arm |=> !st_reg.wr)
		else $error("write began without arm");
	chk_hi_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RQ17
		i_psel && !i_penable && !i_pwrite && i_paddr == NVAC_OFF_ADDR_HI
		|=> st_reg.rdata[31:4] == 28'h0)
		else $error("reserved address bits nonzero");
endmodule

// ---- design/nvac_pkg.sv ----
// Package for the nonvolatile memory access control block.
// Assumes a 32-bit APB slave on a single 125 MHz clock.
package nvac_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] NVAC_OFF_ADDR_LO = 8'h00;
	localparam logic [7:0] NVAC_OFF_ADDR_HI = 8'h04;
	localparam logic [7:0] NVAC_OFF_DATA    = 8'h08;
	localparam logic [7:0] NVAC_OFF_CTRL    = 8'h0c;
	localparam logic [7:0] NVAC_OFF_STAT    = 8'h10;
	localparam logic [7:0] NVAC_OFF_MASK    = 8'h14;
	// ****************************************
	// Control register fields
	// ****************************************
	localparam int NVAC_B_RD    = 0;
	localparam int NVAC_B_WR    = 1;
	localparam int NVAC_B_ARM   = 2;
	localparam int NVAC_B_RIE   = 3;
	localparam int NVAC_B_PM_LO = 4;
	localparam int NVAC_B_GIE   = 6;
	// Status bits: write done, read done, ready
	localparam int NVAC_S_WDONE = 0;
	localparam int NVAC_S_RDONE = 1;
	localparam int NVAC_S_READY = 2;
	localparam int NVAC_NSTAT   = 3;
	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [1:0] NVAC_PM_RST  = 2'h0;
	localparam logic [1:0] NVAC_PM_EW   = 2'h0;
	localparam logic [1:0] NVAC_PM_RSVD = 2'h3;
	localparam int NVAC_ARM_CYC  = 4;
	localparam int NVAC_WR_STALL = 2;
	localparam int NVAC_RD_STALL = 4;
	localparam int NVAC_PROG_OSC = 26368;
	localparam int NVAC_ADDR_W   = 12;
endpackage

// ---- verif/nvac_cpu_model.sv ----
// Processor core model: APB register accesses and the RC oscillator.
// Assumes the bench supplies the block clock and calls xfer.
`timescale 1ns/100ps
module nvac_cpu_model #(
	parameter int P_OSC_HALF = 5
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	input  wire logic [31:0] i_prdata,
	output logic             o_osc_tick,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [7:0]  o_paddr,
	output logic      [31:0] o_pwdata
);
	int osc_cnt;
	initial begin
		{o_osc_tick, o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
		osc_cnt = 0;
	end
	// Oscillator runs free, unrelated to bus traffic
	always @(posedge i_ref_clk) begin
		osc_cnt <= (osc_cnt == P_OSC_HALF - 1) ? 0 : osc_cnt + 1;
		if (osc_cnt == P_OSC_HALF - 1)
			o_osc_tick <= !o_osc_tick;
	end
	// No interrupt handler and no self_program_command here
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge i_ref_clk);
		o_psel    <= 1'b1;
		o_pwrite  <= w;
		o_paddr   <= a;
		o_pwdata  <= d;
		@(posedge i_ref_clk);
		o_penable <= 1'b1;
		do @(posedge i_ref_clk); while (i_pready !== 1'b1);
		q = i_prdata;
		e = i_pslverr;
		o_psel    <= 1'b0;
		o_penable <= 1'b0;
		// Released data must not look valid
		o_pwdata  <= ~d;
	endtask
endmodule

// ---- verif/tb_nvac_ctrl.sv ----
// Self-checking bench for the nonvolatile access control block.
// Assumes the processor model drives the APB and the oscillator.
`timescale 1ns/100ps
module tb_nvac_ctrl;
	import nvac_pkg::*;
	logic        i_ref_clk, i_rst, i_osc_tick, i_psel, i_penable, i_pwrite;
	logic [7:0]  i_paddr, d, v;
	logic [31:0] i_pwdata, o_prdata, q, ctl;
	logic        o_pready, o_pslverr, o_cpu_stall, o_ready_irq, o_irq, err;
	logic [11:0] a;
	int          fails, checks, seed;
	nvac_ctrl #(.P_PROG_OSC(4)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_osc_tick(i_osc_tick), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_cpu_stall(o_cpu_stall), .o_ready_irq(o_ready_irq), .o_irq(o_irq));
	nvac_cpu_model cpu (.i_ref_clk(i_ref_clk), .i_pready(o_pready),
		.i_pslverr(o_pslverr), .i_prdata(o_prdata), .o_osc_tick(i_osc_tick),
		.o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
		.o_paddr(i_paddr), .o_pwdata(i_pwdata));
	// ****************************************
	// Checking and software routines
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		cpu.xfer(1'b1, ad, dt, q, err);
	endtask
	task automatic rd(input logic [7:0] ad);
		cpu.xfer(1'b0, ad, 32'h0, q, err);
	endtask
	function automatic logic [7:0] stored(input logic [1:0] m,
			input logic [7:0] old, input logic [7:0] dt);
		return (m == 2'h1) ? 8'hff : (m == 2'h3) ? old : dt;
	endfunction
	task automatic poll_idle();
		do rd(NVAC_OFF_CTRL); while (q[NVAC_B_WR] !== 1'b0);
	endtask
	task automatic set_addr(input logic [11:0] ad);
		wr(NVAC_OFF_ADDR_LO, {24'h0, ad[7:0]});
		wr(NVAC_OFF_ADDR_HI, {28'h0, ad[11:8]});
	endtask
	task automatic nv_write(input logic [11:0] ad, input logic [7:0] dt,
			input logic [1:0] m);
		poll_idle();
		set_addr(ad);
		wr(NVAC_OFF_DATA, {24'h0, dt});
		ctl = (32'(m) << NVAC_B_PM_LO) | 1 << NVAC_B_RIE | 1 << NVAC_B_GIE;
		wr(NVAC_OFF_CTRL, ctl | 1 << NVAC_B_ARM);
		wr(NVAC_OFF_CTRL, ctl | 1 << NVAC_B_WR);
		#1 chk(o_cpu_stall, 1'b1);
		chk(o_ready_irq, 1'b0);
	endtask
	task automatic nv_read(input logic [11:0] ad);
		poll_idle();
		set_addr(ad);
		wr(NVAC_OFF_CTRL, ctl | 1 << NVAC_B_RD);
		#1 chk(o_cpu_stall, 1'b1);
		rd(NVAC_OFF_DATA);
	endtask
	task automatic final_report();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		#200000;
		fails++;
		final_report();
	end
	initial begin
		fails  = 0;
		checks = 0;
		seed   = 25;
		i_rst  = 1'b1;
		ctl    = 32'h0;
		v      = 8'h10;
		repeat (6) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rd(NVAC_OFF_CTRL);
		chk(q[5:4], NVAC_PM_RST);
		// Every mode, boundary address first, then a random one
		for (int k = 0; k < 2; k++) begin
			a = (k == 0) ? 12'hfff : 12'($random(seed));
			for (int m = 0; m < 4; m++) begin
				d = 8'($random(seed));
				nv_write(a, d, m[1:0]);
				v = stored(m[1:0], v, d);
				nv_read(a);
				chk(q, {24'h0, v});
			end
		end
		// Refusals while programming
		nv_write(12'h5a3, 8'h3c, 2'h0);
		wr(NVAC_OFF_ADDR_LO, 32'h11);
		wr(NVAC_OFF_CTRL, ctl | 1 << NVAC_B_RD | 3 << NVAC_B_PM_LO);
		rd(NVAC_OFF_ADDR_LO);
		chk(q, 32'ha3);
		rd(NVAC_OFF_DATA);
		chk(q, 32'h3c);
		rd(NVAC_OFF_CTRL);
		chk(q[5:1], 5'b00101);
		poll_idle();
		#1 chk(o_ready_irq, 1'b1);
		wr(NVAC_OFF_ADDR_HI, 32'hff);
		rd(NVAC_OFF_ADDR_HI);
		chk(q, 32'h0f);
		// Strobe without arm, and arm left to time out
		wr(NVAC_OFF_CTRL, ctl | 1 << NVAC_B_WR);
		rd(NVAC_OFF_CTRL);
		chk(q[NVAC_B_WR], 1'b0);
		wr(NVAC_OFF_CTRL, ctl | 1 << NVAC_B_ARM);
		repeat (6) @(posedge i_ref_clk);
		wr(NVAC_OFF_CTRL, ctl | 1 << NVAC_B_WR);
		rd(NVAC_OFF_CTRL);
		chk(q[NVAC_B_WR], 1'b0);
		// Status, mask and interrupt line
		wr(NVAC_OFF_STAT, 32'h7);
		wr(NVAC_OFF_MASK, 32'h1);
		#1 chk(o_irq, 1'b0);
		nv_write(12'h001, 8'h55, 2'h0);
		poll_idle();
		#1 chk(o_irq, 1'b1);
		wr(NVAC_OFF_MASK, 32'h0);
		#1 chk(o_irq, 1'b0);
		wr(NVAC_OFF_MASK, 32'h1);
		wr(NVAC_OFF_STAT, 32'h1);
		#1 chk(o_irq, 1'b0);
		rd(8'h3c);
		chk({err, q}, {1'b1, 32'h0});
		final_report();
	end
endmodule
